// >>> stack_block_pkg.sv
package stack_block_pkg;

  // instruction word class that selects the block save / restore group
  localparam logic [5:0] BLOCK_OPCODE = 6'h05;
  // general register index of the status register
  localparam logic [3:0] STATUS_REGISTER_INDEX = 4'h2;
  // stack pointer steps per register, in bytes
  localparam logic [19:0] STACK_STEP_WIDE = 20'h00004;
  localparam logic [19:0] STACK_STEP_WORD = 20'h00002;
  // byte offset of the upper word of a 20-bit item
  localparam logic [19:0] HI_WORD_OFFSET = 20'h00002;
  localparam logic [19:0] STACK_POINTER_RESET = 20'h00000;
  localparam logic [19:0] DATA_RESET = 20'h00000;
  localparam logic [3:0] REG_RESET = 4'h0;

  typedef struct packed {
    logic [5:0] opcode;
    logic restore;
    logic wide;
    logic [3:0] count_m1;
    logic [3:0] dst;
  } instr_t;

  typedef struct packed {
    logic we;
    logic [19:0] addr;
    logic [15:0] wdata;
  } mem_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_LO,
    ST_HI,
    ST_DONE
  } seq_state_t;

endpackage

// >>> multi_register_stack_transfer.sv
// Notes on behaviour
// - count operand covers one to sixteen registers
// - wide restore: two words, stack pointer plus four
// - word restore: one word, stack pointer plus two
// - restore ascends from destination minus count plus one
// - word restore clears register bits nineteen to sixteen
// - flags untouched unless status register restored
// - mode bits change only via restored status register
// - single instruction word, no extension word
// - wide save: full value, stack pointer minus four
// - word save: low sixteen bits, minus two
// - save descends from destination through count registers
// - save changes only stack pointer and memory
`timescale 1ns/100ps
module multi_register_stack_transfer
  import stack_block_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire instr_t instr,
  output logic instr_ready,
  input wire logic [19:0] stack_pointer_in,
  output logic [3:0] rf_raddr,
  input wire logic [19:0] rf_rdata,
  output logic rf_we,
  output logic [3:0] rf_waddr,
  output logic [19:0] rf_wdata,
  output logic stack_pointer_we,
  output logic [19:0] stack_pointer_wdata,
  output logic mem_req,
  output mem_cmd_t mem_cmd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic busy,
  output logic done
);

  seq_state_t state_reg;
  seq_state_t state_next;
  logic restore_reg;
  logic wide_reg;
  logic [3:0] left_reg;
  logic [3:0] cur_reg;
  logic [19:0] stack_pointer_reg;
  logic [19:0] data_reg;
  logic rf_we_reg;
  logic [3:0] rf_waddr_reg;
  logic [19:0] rf_wdata_reg;

  wire idle = (state_reg == ST_IDLE);
  // whole operation comes from one word: class, form and count
  wire accept = idle && instr_valid && (instr.opcode == BLOCK_OPCODE);
  // restore starts at dst - (n-1), save at dst; 4-bit count covers 1..16
  wire [3:0] first_reg = instr.restore ? instr.dst - instr.count_m1 : instr.dst;
  wire [19:0] step = wide_reg ? STACK_STEP_WIDE : STACK_STEP_WORD;
  wire [19:0] stack_pointer_after = restore_reg ? stack_pointer_reg + step
                                                : stack_pointer_reg - step;
  wire in_access = (state_reg == ST_LO) || (state_reg == ST_HI);
  wire last_word = (state_reg == ST_HI) ? restore_reg : !(restore_reg && wide_reg);
  wire reg_done = in_access && mem_ack && last_word;
  wire last_reg = (left_reg == 4'h0);
  wire [19:0] lo_addr = restore_reg ? stack_pointer_reg : stack_pointer_reg - step;
  wire [19:0] hi_addr = restore_reg ? stack_pointer_reg + HI_WORD_OFFSET
                                    : stack_pointer_reg - HI_WORD_OFFSET;
  wire [19:0] mem_addr = (state_reg == ST_HI) ? hi_addr : lo_addr;
  wire mem_write = in_access && !restore_reg;
  // word save stores low 16 bits; wide save adds bits 19:16 above
  wire [15:0] save_word = (state_reg == ST_HI) ? {12'h000, data_reg[19:16]}
                                               : data_reg[15:0];
  // word restore zeroes the upper nibble
  wire [19:0] restored = wide_reg ? {mem_rdata[3:0], data_reg[15:0]}
                                  : {4'h0, mem_rdata};
  // only a restore writes registers; status register only when inside the range
  wire rf_write = reg_done && restore_reg;

  assign instr_ready = idle;
  assign busy = !idle;
  assign done = (state_reg == ST_DONE);
  assign stack_pointer_we = (state_reg == ST_DONE);
  assign stack_pointer_wdata = stack_pointer_reg;
  assign rf_raddr = cur_reg;
  assign rf_we = rf_we_reg;
  assign rf_waddr = rf_waddr_reg;
  assign rf_wdata = rf_wdata_reg;
  assign mem_req = in_access;
  assign mem_cmd = {mem_write, mem_addr, save_word};

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (accept)
          state_next = instr.restore ? ST_LO : ST_FETCH;
      end
      ST_FETCH:
      begin
        // wide save puts the upper word first, at the higher address
        state_next = wide_reg ? ST_HI : ST_LO;
      end
      ST_LO:
      begin
        if (mem_ack)
        begin
          if (!last_word)
            state_next = ST_HI;
          else if (last_reg)
            state_next = ST_DONE;
          else
            state_next = restore_reg ? ST_LO : ST_FETCH;
        end
      end
      ST_HI:
      begin
        if (mem_ack)
        begin
          if (!last_word)
            state_next = ST_LO;
          else if (last_reg)
            state_next = ST_DONE;
          else
            state_next = ST_LO;
        end
      end
      ST_DONE:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      restore_reg <= 1'b0;
      wide_reg <= 1'b0;
      left_reg <= REG_RESET;
      cur_reg <= REG_RESET;
      stack_pointer_reg <= STACK_POINTER_RESET;
    end
    else if (accept)
    begin
      restore_reg <= instr.restore;
      wide_reg <= instr.wide;
      left_reg <= instr.count_m1;
      cur_reg <= first_reg;
      stack_pointer_reg <= stack_pointer_in;
    end
    else if (reg_done)
    begin
      stack_pointer_reg <= stack_pointer_after;
      if (!last_reg)
      begin
        left_reg <= left_reg - 4'h1;
        cur_reg <= restore_reg ? cur_reg + 4'h1 : cur_reg - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      data_reg <= DATA_RESET;
    else if (state_reg == ST_FETCH)
      data_reg <= rf_rdata;
    else if (restore_reg && state_reg == ST_LO && mem_ack)
      data_reg <= {4'h0, mem_rdata};
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rf_we_reg <= 1'b0;
      rf_waddr_reg <= REG_RESET;
      rf_wdata_reg <= DATA_RESET;
    end
    else
    begin
      rf_we_reg <= rf_write;
      if (rf_write)
      begin
        rf_waddr_reg <= cur_reg;
        rf_wdata_reg <= restored;
      end
    end
  end

  count_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    accept |=> left_reg == $past(instr.count_m1))
    else $error("count not loaded from instruction");

  wide_restore_step_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_done && restore_reg && wide_reg) |=>
      stack_pointer_reg == $past(stack_pointer_reg) + STACK_STEP_WIDE)
    else $error("wide restore stack step wrong");

  word_restore_step_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_done && restore_reg && !wide_reg) |=>
      stack_pointer_reg == $past(stack_pointer_reg) + STACK_STEP_WORD)
    else $error("word restore stack step wrong");

  restore_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (accept && instr.restore) |=> cur_reg == $past(instr.dst) - $past(instr.count_m1))
    else $error("restore start register wrong");

  word_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (rf_we_reg && !wide_reg) |-> rf_wdata_reg[19:16] == 4'h0)
    else $error("word restore left upper bits set");

  wide_save_step_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_done && !restore_reg && wide_reg) |=>
      stack_pointer_reg == $past(stack_pointer_reg) - STACK_STEP_WIDE)
    else $error("wide save stack step wrong");

  word_save_step_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (reg_done && !restore_reg && !wide_reg) |=>
      stack_pointer_reg == $past(stack_pointer_reg) - STACK_STEP_WORD)
    else $error("word save stack step wrong");

  save_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (accept && !instr.restore) |=> cur_reg == $past(instr.dst))
    else $error("save start register wrong");

  save_no_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (busy && !restore_reg) |-> ##1 !rf_we_reg)
    else $error("save wrote a register");

endmodule

// >>> stack_memory_model.sv
`timescale 1ns/100ps
module stack_memory_model
  import stack_block_pkg::*;
(
  input wire logic ref_clk,
  input wire logic mem_req,
  input wire mem_cmd_t mem_cmd,
  input wire logic [1:0] wait_cycles,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:127];
  logic [1:0] wait_reg = 2'h0;
  wire logic [6:0] idx = mem_cmd.addr[7:1];
  assign mem_ack = mem_req && (wait_reg == wait_cycles);
  // data not valid before ack, so show a changed word
  assign mem_rdata = mem_ack ? mem[idx] : ~mem[idx];
  always @(posedge ref_clk)
  begin
    wait_reg <= (mem_req && !mem_ack) ? wait_reg + 2'h1 : 2'h0;
    if (mem_ack && mem_cmd.we)
      mem[idx] <= mem_cmd.wdata;
  end
endmodule

// >>> multi_register_stack_transfer_test.sv
`timescale 1ns/100ps
module multi_register_stack_transfer_test
  import stack_block_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0;
  instr_t instr = '0;
  logic [19:0] stack_pointer_in = 20'h0, stack_pointer_after, v;
  logic [1:0] wait_cycles = 2'h0;
  logic instr_ready, rf_we, stack_pointer_we, mem_req, mem_ack, busy, done;
  logic [3:0] rf_raddr, rf_waddr;
  logic [19:0] rf_wdata, stack_pointer_wdata;
  logic [15:0] mem_rdata;
  mem_cmd_t mem_cmd;
  logic [19:0] rf [0:15];
  int errors = 0, checks_done = 0;
  assign v = rf[rf_raddr];
  always @(posedge ref_clk)
    if (rf_we) rf[rf_waddr] <= rf_wdata;
  multi_register_stack_transfer i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .stack_pointer_in(stack_pointer_in),
    .rf_raddr(rf_raddr), .rf_rdata(v), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata), .stack_pointer_we(stack_pointer_we),
    .stack_pointer_wdata(stack_pointer_wdata), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done));
  stack_memory_model i_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [19:0] pat(input int i);
    pat = {i[3:0], 8'h5a, i[3:0], ~i[3:0]};
  endfunction
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic fill(input logic blank);
    for (int i = 0; i < 16; i++) rf[i] = blank ? 20'hfffff : pat(i);
  endtask
  task automatic run(input logic r, w, input logic [3:0] nm1, d, input logic [19:0] start_ptr);
    int n;
    @(posedge ref_clk);
    #1;
    instr = {BLOCK_OPCODE, r, w, nm1, d};
    stack_pointer_in = start_ptr;
    instr_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 500)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 500)
    begin
      errors++;
      finish_test();
    end
    chk({19'h0, stack_pointer_we}, 20'h00001);
    stack_pointer_after = stack_pointer_wdata;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic scen_wide();
    int a;
    fill(1'b0);
    wait_cycles = 2'h0;
    run(1'b0, 1'b1, 4'h1, 4'h5, 20'h00080);
    chk(stack_pointer_after, 20'h00078);
    for (int k = 0; k < 2; k++)
    begin
      a = ('h80 - 4 * (k + 1)) / 2;
      chk({4'h0, i_mem.mem[a]}, pat(5 - k) & 20'h0ffff);
      chk({4'h0, i_mem.mem[a + 1]}, pat(5 - k) >> 16);
      chk(rf[5 - k], pat(5 - k));
    end
    fill(1'b1);
    run(1'b1, 1'b1, 4'h1, 4'h5, stack_pointer_after);
    chk(stack_pointer_after, 20'h00080);
    for (int k = 4; k < 6; k++) chk(rf[k], pat(k));
    chk(rf[STATUS_REGISTER_INDEX], 20'hfffff);
    chk(rf[6], 20'hfffff);
  endtask
  task automatic scen_word();
    fill(1'b0);
    wait_cycles = 2'h2;
    run(1'b0, 1'b0, 4'hf, 4'hf, 20'h00080);
    chk(stack_pointer_after, 20'h00060);
    for (int k = 0; k < 16; k++)
    begin
      chk({4'h0, i_mem.mem[63 - k]}, pat(15 - k) & 20'h0ffff);
      chk(rf[k], pat(k));
    end
    fill(1'b1);
    run(1'b1, 1'b0, 4'hf, 4'hf, 20'h00060);
    chk(stack_pointer_after, 20'h00080);
    for (int i = 0; i < 16; i++) chk(rf[i], pat(i) & 20'h0ffff);
    chk(rf[STATUS_REGISTER_INDEX], pat(2) & 20'h0ffff);
  endtask
  task automatic scen_other();
    @(posedge ref_clk);
    #1;
    instr = {6'h06, 10'h3f5};
    instr_valid = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    chk({19'h0, busy}, 20'h0);
    chk({19'h0, instr_ready}, 20'h00001);
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    scen_wide();
    scen_word();
    scen_other();
    finish_test();
  end
endmodule
